// [design/rtcr_top.sv]
`timescale 1ns/1ps
module rtcr_top #(
    parameter int unsigned SECOND_CYCLES = rtcr_pkg::SECOND_CYCLES
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Host parallel port
    input  wire logic       csN,
    input  wire logic       oeN,
    input  wire logic       weN,
    input  wire logic [3:0] regIndex,
    input  wire logic [7:0] busLinesIn,
    output logic      [7:0] busLinesOut,
    output logic            busLinesOeN,
    // Supply status
    input  wire logic       batteryValid,
    input  wire logic       backupMode,
    // Event sources
    input  wire logic       matchEvent,
    input  wire logic       periodicEvent,
    input  wire logic       powerfailEvent,
    // Open-drain interrupt pin
    output logic            intPinOut,
    output logic            intPinOeN
);

    localparam logic [rtcr_pkg::TICK_W-1:0] TICK_LAST =
        rtcr_pkg::TICK_W'(SECOND_CYCLES - 1);

    logic [7:0] cnt_r [rtcr_pkg::T_COUNT];
    logic [7:0] usr_r [rtcr_pkg::T_COUNT];
    logic [7:0] cnt_nxt [rtcr_pkg::T_COUNT];
    logic [7:0] match_r [4];
    logic [7:0] rate_r;
    logic [7:0] enable_r;
    logic [7:0] ctrl_r;
    logic [3:1] flags_r;
    logic [3:1] flags_nxt;
    logic [rtcr_pkg::TICK_W-1:0] tick_r;
    logic       xferPending_r;
    logic       timeDirty_r;
    logic       dstFallDone_r;
    logic       dstFallDone_nxt;
    logic       wrActive_r;
    logic [3:0] wrIndex_r;
    logic [7:0] wrData_r;
    logic       rdFlags_r;
    logic [7:0] busLinesOut_r;
    logic       busLinesOeN_r;
    logic       intPinOeN_r;

    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [2:0] timeSlot(input logic [3:0] a);
        case (a)
            rtcr_pkg::ADDR_SEC:   timeSlot = rtcr_pkg::T_SEC;
            rtcr_pkg::ADDR_MIN:   timeSlot = rtcr_pkg::T_MIN;
            rtcr_pkg::ADDR_HOUR:  timeSlot = rtcr_pkg::T_HOUR;
            rtcr_pkg::ADDR_DATE:  timeSlot = rtcr_pkg::T_DATE;
            rtcr_pkg::ADDR_WDAY:  timeSlot = rtcr_pkg::T_WDAY;
            rtcr_pkg::ADDR_MONTH: timeSlot = rtcr_pkg::T_MONTH;
            default:              timeSlot = rtcr_pkg::T_YEAR;
        endcase
    endfunction

    // Port decode. Write enable low takes priority over a read.
    wire rdActive   = !csN && !oeN && weN;
    wire wrActive   = !csN && !weN;
    wire wrCommit   = wrActive_r && !wrActive;
    wire isTimeRd   = (regIndex <= rtcr_pkg::ADDR_YEAR) && (!regIndex[0] || regIndex[3]);
    wire isTimeWr   = (wrIndex_r <= rtcr_pkg::ADDR_YEAR) && (!wrIndex_r[0] || wrIndex_r[3]);
    wire isMatchWr  = !wrIndex_r[3] && wrIndex_r[0];
    wire [2:0] rdSlot = timeSlot(regIndex);
    wire [2:0] wrSlot = timeSlot(wrIndex_r);
    wire ctrlWr     = wrCommit && (wrIndex_r == rtcr_pkg::ADDR_CONTROL);
    wire freezeOn   = ctrl_r[rtcr_pkg::CTRL_FREEZE_BIT];
    wire unfreeze   = ctrlWr && freezeOn && !wrData_r[rtcr_pkg::CTRL_FREEZE_BIT];
    wire fmt24      = ctrl_r[rtcr_pkg::CTRL_FMT24_BIT];
    wire dstOn      = ctrl_r[rtcr_pkg::CTRL_DST_BIT];

    // The divider halts with the oscillator, so a stopped clock loses no phase.
    wire running    = !backupMode || ctrl_r[rtcr_pkg::CTRL_RUN_BIT];
    wire secondTick = running && (tick_r == TICK_LAST);

    // Flag register: a read of it clears the events when the read ends.
    wire rdFlagsNow = rdActive && (regIndex == rtcr_pkg::ADDR_FLAGS);
    wire flagsClear = rdFlags_r && !rdFlagsNow;
    wire [3:1] flagEvents = {matchEvent, periodicEvent, powerfailEvent};
    wire [7:0] flagsByte  = {4'h0, flags_r, batteryValid};
    wire intAsserted      = |(flags_r & enable_r[3:1]);

    // Read data mux.
    wire [7:0] rdData =
        isTimeRd                              ? usr_r[rdSlot] :
        !regIndex[3]                          ? match_r[regIndex[2:1]] :
        (regIndex == rtcr_pkg::ADDR_RATE)     ? rate_r :
        (regIndex == rtcr_pkg::ADDR_ENABLE)   ? enable_r :
        (regIndex == rtcr_pkg::ADDR_FLAGS)    ? flagsByte :
        (regIndex == rtcr_pkg::ADDR_CONTROL)  ? ctrl_r :
        rtcr_pkg::ZERO_BYTE;

    // Calendar helpers on the internal counters.
    wire [7:0] yr        = cnt_r[rtcr_pkg::T_YEAR];
    wire       leapYear  = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    wire [7:0] mon       = cnt_r[rtcr_pkg::T_MONTH];
    wire       shortMon  = (mon == rtcr_pkg::MONTH_APR) || (mon == rtcr_pkg::MONTH_JUN) ||
                           (mon == rtcr_pkg::MONTH_SEP) || (mon == rtcr_pkg::MONTH_NOV);
    wire [7:0] monthLen  = (mon == rtcr_pkg::MONTH_FEB) ? (leapYear ? rtcr_pkg::BCD_29
                                                                    : rtcr_pkg::BCD_28) :
                           shortMon ? rtcr_pkg::BCD_30 : rtcr_pkg::BCD_31;
    wire       isSunday  = cnt_r[rtcr_pkg::T_WDAY] == rtcr_pkg::SUNDAY;
    wire       springDay = dstOn && isSunday && (mon == rtcr_pkg::MONTH_APR) &&
                           (cnt_r[rtcr_pkg::T_DATE] <= rtcr_pkg::FIRST_WEEK_LAST);
    wire       fallDay   = dstOn && isSunday && (mon == rtcr_pkg::MONTH_OCT) &&
                           (cnt_r[rtcr_pkg::T_DATE] >= rtcr_pkg::LAST_WEEK_FIRST);

    // One-second advance of the internal counters.
    always_comb
    begin
        logic       minStep;
        logic       hourStep;
        logic       dayStep;
        logic       monStep;
        logic       yearStep;
        logic [7:0] h;
        logic [7:0] hn;
        minStep  = 1'b0;
        hourStep = 1'b0;
        dayStep  = 1'b0;
        monStep  = 1'b0;
        yearStep = 1'b0;
        h        = cnt_r[rtcr_pkg::T_HOUR];
        hn       = h;
        dstFallDone_nxt = dstFallDone_r && (mon == rtcr_pkg::MONTH_OCT);
        cnt_nxt = cnt_r;
        minStep = cnt_r[rtcr_pkg::T_SEC] == rtcr_pkg::BCD_59;
        cnt_nxt[rtcr_pkg::T_SEC] = minStep ? rtcr_pkg::ZERO_BYTE
                                           : bcdInc(cnt_r[rtcr_pkg::T_SEC]);
        if (minStep)
        begin
            hourStep = cnt_r[rtcr_pkg::T_MIN] == rtcr_pkg::BCD_59;
            cnt_nxt[rtcr_pkg::T_MIN] = hourStep ? rtcr_pkg::ZERO_BYTE
                                                : bcdInc(cnt_r[rtcr_pkg::T_MIN]);
        end
        if (hourStep)
        begin
            if (fmt24)
            begin
                dayStep = h == rtcr_pkg::BCD_23;
                hn      = dayStep ? rtcr_pkg::ZERO_BYTE : bcdInc(h);
            end
            else if ({1'b0, h[6:0]} == rtcr_pkg::BCD_11)
            begin
                dayStep = h[rtcr_pkg::PM_BIT];
                hn      = {!h[rtcr_pkg::PM_BIT], rtcr_pkg::BCD_12[6:0]};
            end
            else if ({1'b0, h[6:0]} == rtcr_pkg::BCD_12)
            begin
                hn = {h[rtcr_pkg::PM_BIT], rtcr_pkg::ONE_BCD[6:0]};
            end
            else
            begin
                hn = {h[rtcr_pkg::PM_BIT], 7'(bcdInc({1'b0, h[6:0]}))};
            end
            // Spring forward skips 2 AM; fall back repeats 1 AM once only.
            if (hn == rtcr_pkg::BCD_02 && springDay)
            begin
                hn = rtcr_pkg::BCD_03;
            end
            else if (hn == rtcr_pkg::BCD_02 && fallDay && !dstFallDone_r)
            begin
                hn              = rtcr_pkg::ONE_BCD;
                dstFallDone_nxt = 1'b1;
            end
            cnt_nxt[rtcr_pkg::T_HOUR] = hn;
        end
        if (dayStep)
        begin
            cnt_nxt[rtcr_pkg::T_WDAY] =
                (cnt_r[rtcr_pkg::T_WDAY] == rtcr_pkg::SATURDAY) ? rtcr_pkg::SUNDAY
                                                                 : bcdInc(cnt_r[rtcr_pkg::T_WDAY]);
            monStep = cnt_r[rtcr_pkg::T_DATE] == monthLen;
            cnt_nxt[rtcr_pkg::T_DATE] = monStep ? rtcr_pkg::ONE_BCD
                                                : bcdInc(cnt_r[rtcr_pkg::T_DATE]);
        end
        if (monStep)
        begin
            yearStep = mon == rtcr_pkg::BCD_12;
            cnt_nxt[rtcr_pkg::T_MONTH] = yearStep ? rtcr_pkg::ONE_BCD : bcdInc(mon);
        end
        if (yearStep)
        begin
            cnt_nxt[rtcr_pkg::T_YEAR] = (yr == rtcr_pkg::BCD_99) ? rtcr_pkg::ZERO_BYTE
                                                                : bcdInc(yr);
        end
    end

    assign flags_nxt = (flags_r & ~{3{flagsClear}}) | flagEvents;

    // Port sampling: the last byte seen while the write was active is the one stored.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrActive_r <= 1'b0;
            wrIndex_r  <= 4'h0;
            wrData_r   <= 8'h00;
            rdFlags_r  <= 1'b0;
        end
        else
        begin
            wrActive_r <= wrActive;
            rdFlags_r  <= rdFlagsNow;
            if (wrActive)
            begin
                wrIndex_r <= regIndex;
                wrData_r  <= busLinesIn;
            end
        end
    end

    // Pins come from flops, so outputs lag the strobes by one clock.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busLinesOut_r <= 8'h00;
            busLinesOeN_r <= 1'b1;
            intPinOeN_r   <= 1'b1;
        end
        else
        begin
            busLinesOeN_r <= !rdActive;
            busLinesOut_r <= rdData;
            intPinOeN_r   <= !intAsserted;
        end
    end

    // Control, rate, enable, match and flag registers.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rate_r   <= rtcr_pkg::RATE_RESET;
            enable_r <= rtcr_pkg::ENABLE_RESET;
            ctrl_r   <= rtcr_pkg::CTRL_RESET;
            flags_r  <= 3'h0;
            match_r  <= '{default: rtcr_pkg::ZERO_BYTE};
        end
        else
        begin
            flags_r <= flags_nxt;
            if (wrCommit && isMatchWr)
            begin
                match_r[wrIndex_r[2:1]] <= wrData_r;
            end
            if (wrCommit && wrIndex_r == rtcr_pkg::ADDR_RATE)
            begin
                rate_r <= wrData_r & rtcr_pkg::RATE_MASK;
            end
            if (wrCommit && wrIndex_r == rtcr_pkg::ADDR_ENABLE)
            begin
                enable_r <= wrData_r & rtcr_pkg::LOW4_MASK;
            end
            if (ctrlWr)
            begin
                ctrl_r <= wrData_r & rtcr_pkg::LOW4_MASK;
            end
        end
    end

    // Time base and internal counters; they never pause for a freeze.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tick_r        <= '0;
            dstFallDone_r <= 1'b0;
            for (int i = 0; i < rtcr_pkg::T_COUNT; i++)
            begin
                cnt_r[i] <= (i == 3 || i == 4 || i == 5) ? rtcr_pkg::ONE_BCD
                                                         : rtcr_pkg::ZERO_BYTE;
            end
        end
        else
        begin
            if (running)
            begin
                tick_r <= secondTick ? '0 : tick_r + 1'b1;
            end
            // A freeze used only for reading reloads nothing, so no time is lost.
            if (unfreeze && timeDirty_r)
            begin
                cnt_r <= usr_r;
            end
            else if (secondTick)
            begin
                cnt_r         <= cnt_nxt;
                dstFallDone_r <= dstFallDone_nxt;
            end
        end
    end

    // User-visible copies, updated one clock after the tick.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            xferPending_r <= 1'b0;
            timeDirty_r   <= 1'b0;
            for (int i = 0; i < rtcr_pkg::T_COUNT; i++)
            begin
                usr_r[i] <= (i == 3 || i == 4 || i == 5) ? rtcr_pkg::ONE_BCD
                                                         : rtcr_pkg::ZERO_BYTE;
            end
        end
        else
        begin
            xferPending_r <= secondTick;
            timeDirty_r   <= (timeDirty_r || (wrCommit && isTimeWr && freezeOn)) && !unfreeze;
            // The freeze bit is sampled before a same-cycle write lands, so a copy
            // already under way always completes.
            if (xferPending_r && !freezeOn)
            begin
                usr_r <= cnt_r;
            end
            if (wrCommit && isTimeWr)
            begin
                usr_r[wrSlot] <= (wrSlot == rtcr_pkg::T_WDAY) ? (wrData_r & rtcr_pkg::WDAY_MASK)
                                                              : wrData_r;
            end
        end
    end

    assign busLinesOut = busLinesOut_r;
    assign busLinesOeN = busLinesOeN_r;
    assign intPinOut   = 1'b0;
    assign intPinOeN   = intPinOeN_r;

endmodule

// [shared/rtcr_pkg.sv]
package rtcr_pkg;

    // Register locations on the four index lines.
    localparam logic [3:0] ADDR_SEC         = 4'h0;
    localparam logic [3:0] ADDR_SEC_MATCH   = 4'h1;
    localparam logic [3:0] ADDR_MIN         = 4'h2;
    localparam logic [3:0] ADDR_MIN_MATCH   = 4'h3;
    localparam logic [3:0] ADDR_HOUR        = 4'h4;
    localparam logic [3:0] ADDR_HOUR_MATCH  = 4'h5;
    localparam logic [3:0] ADDR_DATE        = 4'h6;
    localparam logic [3:0] ADDR_DATE_MATCH  = 4'h7;
    localparam logic [3:0] ADDR_WDAY        = 4'h8;
    localparam logic [3:0] ADDR_MONTH       = 4'h9;
    localparam logic [3:0] ADDR_YEAR        = 4'hA;
    localparam logic [3:0] ADDR_RATE        = 4'hB;
    localparam logic [3:0] ADDR_ENABLE      = 4'hC;
    localparam logic [3:0] ADDR_FLAGS       = 4'hD;
    localparam logic [3:0] ADDR_CONTROL     = 4'hE;
    localparam logic [3:0] ADDR_SPARE       = 4'hF;

    // Index of each time field in the counter arrays.
    localparam logic [2:0] T_SEC   = 3'h0;
    localparam logic [2:0] T_MIN   = 3'h1;
    localparam logic [2:0] T_HOUR  = 3'h2;
    localparam logic [2:0] T_DATE  = 3'h3;
    localparam logic [2:0] T_WDAY  = 3'h4;
    localparam logic [2:0] T_MONTH = 3'h5;
    localparam logic [2:0] T_YEAR  = 3'h6;
    localparam int         T_COUNT = 7;

    // Control, enable and flag bit positions.
    localparam int CTRL_FREEZE_BIT = 3;
    localparam int CTRL_RUN_BIT    = 2;
    localparam int CTRL_FMT24_BIT  = 1;
    localparam int CTRL_DST_BIT    = 0;
    localparam int FLAG_MATCH_BIT  = 3;
    localparam int FLAG_PERIOD_BIT = 2;
    localparam int FLAG_PWR_BIT    = 1;
    localparam int FLAG_BATT_BIT   = 0;
    localparam int PM_BIT          = 7;

    // Writable bit masks and reset values.
    localparam logic [7:0] RATE_MASK    = 8'h7F;
    localparam logic [7:0] LOW4_MASK    = 8'h0F;
    localparam logic [7:0] WDAY_MASK    = 8'h07;
    localparam logic [7:0] CTRL_RESET   = 8'h06;
    localparam logic [7:0] RATE_RESET   = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    localparam logic [7:0] ONE_BCD      = 8'h01;

    // BCD limits and calendar constants.
    localparam logic [7:0] BCD_02  = 8'h02;
    localparam logic [7:0] BCD_03  = 8'h03;
    localparam logic [7:0] BCD_11  = 8'h11;
    localparam logic [7:0] BCD_12  = 8'h12;
    localparam logic [7:0] BCD_23  = 8'h23;
    localparam logic [7:0] BCD_28  = 8'h28;
    localparam logic [7:0] BCD_29  = 8'h29;
    localparam logic [7:0] BCD_30  = 8'h30;
    localparam logic [7:0] BCD_31  = 8'h31;
    localparam logic [7:0] BCD_59  = 8'h59;
    localparam logic [7:0] BCD_99  = 8'h99;
    localparam logic [7:0] MONTH_FEB  = 8'h02;
    localparam logic [7:0] MONTH_APR  = 8'h04;
    localparam logic [7:0] MONTH_JUN  = 8'h06;
    localparam logic [7:0] MONTH_SEP  = 8'h09;
    localparam logic [7:0] MONTH_OCT  = 8'h10;
    localparam logic [7:0] MONTH_NOV  = 8'h11;
    localparam logic [7:0] SUNDAY     = 8'h01;
    localparam logic [7:0] SATURDAY   = 8'h07;
    localparam logic [7:0] FIRST_WEEK_LAST = 8'h07;
    localparam logic [7:0] LAST_WEEK_FIRST = 8'h25;

    // Time base: one second at the 20 MHz system clock.
    localparam int ONE_SECOND_MS  = 1000;
    localparam int CLOCK_KHZ      = 20000;
    localparam int SECOND_CYCLES  = ONE_SECOND_MS * CLOCK_KHZ;
    localparam int TICK_W         = 25;

endpackage

// [test/rtcr_host_model.sv]
`timescale 1ns/1ps
module rtcr_host_model (
    // Clock
    input  wire logic       clock,
    // Port pins
    output logic            csN,
    output logic            oeN,
    output logic            weN,
    output logic      [3:0] regIndex,
    output logic      [7:0] busLinesIn,
    input  wire logic [7:0] busLinesOut,
    input  wire logic       busLinesOeN
);
    logic [7:0] lastSeen;
    initial
    begin
        csN        = 1'b1;
        oeN        = 1'b1;
        weN        = 1'b1;
        regIndex   = 4'h0;
        busLinesIn = 8'h5A;
        lastSeen   = 8'h00;
    end
    task automatic write_reg(input logic [3:0] idx, input logic [7:0] data);
        @(negedge clock);
        regIndex   = idx; // Held until the write has ended.
        busLinesIn = data;
        csN        = 1'b0;
        weN        = 1'b0; // Output enable stays high to avoid contention.
        @(negedge clock);
        weN        = 1'b1;
        csN        = 1'b1;
        @(negedge clock);
        busLinesIn = ~data; // Recovery cycle; a released bus shows no stale byte.
    endtask
    task automatic read_reg(input logic [3:0] idx, output logic [7:0] data);
        @(negedge clock);
        regIndex = idx;
        csN      = 1'b0;
        oeN      = 1'b0;
        @(negedge clock);
        data     = busLinesOeN ? ~lastSeen : busLinesOut;
        lastSeen = data;
        oeN      = 1'b1;
        csN      = 1'b1;
        @(negedge clock);
    endtask
endmodule

// [test/rtcr_props.sv]
`timescale 1ns/1ps
module rtcr_props (
    // Clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // Host port
    input wire logic       csN,
    input wire logic       oeN,
    input wire logic       weN,
    input wire logic [3:0] regIndex,
    input wire logic [7:0] busLinesOut,
    input wire logic       busLinesOeN,
    // Status, events and interrupt pin
    input wire logic       batteryValid,
    input wire logic       matchEvent,
    input wire logic       periodicEvent,
    input wire logic       powerfailEvent,
    input wire logic       intPinOut,
    input wire logic       intPinOeN
);
    wire logic rdMode;
    wire logic quiet;
    assign rdMode = !csN && !oeN && weN;
    assign quiet  = !matchEvent && !periodicEvent && !powerfailEvent;
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    a_read_drive: assert property (rdMode |=> !busLinesOeN)
        else $error("read not driven");
    a_idle_float: assert property ((csN || oeN) |=> busLinesOeN)
        else $error("lines driven when idle");
    a_write_release: assert property ((!csN && !weN) |=> busLinesOeN)
        else $error("lines driven in write");
    a_spare_zero: assert property ((rdMode && regIndex == 4'hF) |=> busLinesOut == 8'h00)
        else $error("spare not zero");
    a_ctrl_unused: assert property ((rdMode && regIndex == 4'hE) |=> busLinesOut[7:4] == 4'h0)
        else $error("control top bits set");
    a_batt_flag: assert property ((rdMode && regIndex == 4'hD)
        |=> busLinesOut[0] == $past(batteryValid))
        else $error("battery flag wrong");
    a_wday_range: assert property ((rdMode && regIndex == 4'h8)
        |=> busLinesOut inside {[8'h01:8'h07]})
        else $error("weekday out of range");
    a_flag_release: assert property ((rdMode && regIndex == 4'hD && quiet)
        ##1 (!rdMode && quiet) |=> ##1 intPinOeN)
        else $error("interrupt kept after flag read");
    a_int_level: assert property (!intPinOeN |-> intPinOut == 1'b0)
        else $error("interrupt pin not low");
    c_flag_read: cover property (rdMode && regIndex == 4'hD);
    c_write: cover property (!csN && !weN);
    c_int: cover property (!intPinOeN);
endmodule
bind rtcr_top rtcr_props chk (
    .clock(clock),
    .sys_rst(sys_rst),
    .csN(csN),
    .oeN(oeN),
    .weN(weN),
    .regIndex(regIndex),
    .busLinesOut(busLinesOut),
    .busLinesOeN(busLinesOeN),
    .batteryValid(batteryValid),
    .matchEvent(matchEvent),
    .periodicEvent(periodicEvent),
    .powerfailEvent(powerfailEvent),
    .intPinOut(intPinOut),
    .intPinOeN(intPinOeN)
);

// [test/test_rtcr_top.sv]
`timescale 1ns/1ps
module test_rtcr_top;
    localparam int SEC = 20;
    logic       clock;
    logic       sys_rst;
    logic       csN;
    logic       oeN;
    logic       weN;
    logic [3:0] regIndex;
    logic [7:0] busLinesIn;
    logic [7:0] busLinesOut;
    logic       busLinesOeN;
    logic       batteryValid;
    logic       backupMode;
    logic       matchEvent;
    logic       periodicEvent;
    logic       powerfailEvent;
    logic       intPinOut;
    logic       intPinOeN;
    int         failures;
    int         checks_done;
    int         cycles;
    logic [7:0] seed;
    logic [7:0] got;
    logic [7:0] prev;
    logic [7:0] rwExp [6];
    logic [3:0] rwIdx [6] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'hB, 4'hC};
    logic [7:0] rwMsk [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h0F};
    logic [3:0] tIdx [7] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'hA};
    logic [7:0] tVal [7] = '{8'h58, 8'h59, 8'h23, 8'h28, 8'h07, 8'h02, 8'h04};
    logic [7:0] eVal [7] = '{8'h00, 8'h00, 8'h00, 8'h29, 8'h01, 8'h02, 8'h04};
    rtcr_top #(.SECOND_CYCLES(SEC)) dut (.clock(clock), .sys_rst(sys_rst), .csN(csN),
        .oeN(oeN), .weN(weN), .regIndex(regIndex), .busLinesIn(busLinesIn),
        .busLinesOut(busLinesOut), .busLinesOeN(busLinesOeN), .batteryValid(batteryValid),
        .backupMode(backupMode), .matchEvent(matchEvent), .periodicEvent(periodicEvent),
        .powerfailEvent(powerfailEvent), .intPinOut(intPinOut), .intPinOeN(intPinOeN));
    rtcr_host_model host (.clock(clock), .csN(csN), .oeN(oeN), .weN(weN),
        .regIndex(regIndex), .busLinesIn(busLinesIn), .busLinesOut(busLinesOut),
        .busLinesOeN(busLinesOeN));
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] bcd_inc(input logic [7:0] x);
        return (x[3:0] == 4'h9) ? {x[7:4] + 4'h1, 4'h0} : x + 8'h01;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want)
        begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] want);
        logic [7:0] seen;
        host.read_reg(idx, seen);
        check(seen, want);
    endtask
    // The poll is bounded by about one and a half seconds of reads.
    task automatic poll_change(input logic [7:0] old);
        got = old;
        for (int n = 0; n < SEC / 2 && got === old; n++)
            host.read_reg(4'h0, got);
    endtask
    task automatic roll_hour(input logic [7:0] ctrl, input logic [7:0] hour,
                             input logic [7:0] want);
        host.write_reg(4'hE, ctrl | 8'h08);
        host.write_reg(4'h0, 8'h59);
        host.write_reg(4'h2, 8'h59);
        host.write_reg(4'h4, hour);
        host.write_reg(4'hE, ctrl);
        poll_change(8'h59);
        check(got, 8'h00);
        rd_chk(4'h4, want);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            final_report();
        end
    end
    initial
    begin
        {sys_rst, batteryValid} = 2'b11;
        {backupMode, matchEvent, periodicEvent, powerfailEvent} = 4'h0;
        {failures, checks_done, cycles} = '0;
        seed = 8'h39;
        repeat (4) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        rd_chk(4'hE, 8'h06);
        host.write_reg(4'hF, 8'hFF);
        rd_chk(4'hF, 8'h00);
        host.write_reg(4'hE, 8'hF6);
        rd_chk(4'hE, 8'h06);
        host.write_reg(4'hD, 8'hFF);
        rd_chk(4'hD, {7'h00, batteryValid});
        $display("test unused bits done");
        for (int k = 0; k < 12; k++)
        begin
            seed = lfsr_next(seed);
            batteryValid = seed[0];
            rwExp[k % 6] = seed & rwMsk[k % 6];
            host.write_reg(rwIdx[k % 6], seed);
            rd_chk(4'hD, {7'h00, batteryValid});
        end
        for (int k = 0; k < 6; k++)
            rd_chk(rwIdx[k], rwExp[k]);
        $display("test register decode done");
        host.write_reg(4'hC, 8'h08);
        {periodicEvent, powerfailEvent} = 2'b11;
        @(negedge clock);
        {periodicEvent, powerfailEvent} = 2'b00;
        repeat (3) @(negedge clock);
        check({7'h00, intPinOeN}, 8'h01);
        matchEvent = 1'b1;
        @(negedge clock);
        matchEvent = 1'b0;
        repeat (3) @(negedge clock);
        check({6'h00, intPinOut, intPinOeN}, 8'h00);
        rd_chk(4'hD, {7'h07, batteryValid});
        repeat (2) @(negedge clock);
        check({7'h00, intPinOeN}, 8'h01);
        rd_chk(4'hD, {7'h00, batteryValid});
        $display("test event flags done");
        host.write_reg(4'hE, 8'h0E);
        for (int k = 0; k < 7; k++)
            host.write_reg(tIdx[k], tVal[k]);
        repeat (3 * SEC) @(negedge clock);
        rd_chk(4'h0, 8'h58);
        host.write_reg(4'hE, 8'h06);
        poll_change(8'h58);
        check(got, 8'h59);
        poll_change(8'h59);
        check(got, 8'h00);
        host.write_reg(4'hE, 8'h0E);
        for (int k = 0; k < 7; k++)
            rd_chk(tIdx[k], eVal[k]);
        repeat (2 * SEC) @(negedge clock);
        host.write_reg(4'hE, 8'h06);
        poll_change(8'h00);
        check(got, 8'h04);
        $display("test set and roll over done");
        host.write_reg(4'hE, 8'h02);
        backupMode = 1'b1;
        repeat (2) @(negedge clock);
        host.read_reg(4'h0, prev);
        repeat (3 * SEC) @(negedge clock);
        rd_chk(4'h0, prev);
        backupMode = 1'b0;
        poll_change(prev);
        check(got, bcd_inc(prev));
        $display("test stop in backup done");
        roll_hour(8'h04, 8'h11, 8'h92);
        host.write_reg(4'hE, 8'h0B);
        host.write_reg(4'h6, 8'h01);
        host.write_reg(4'h8, 8'h01);
        host.write_reg(4'h9, 8'h04);
        roll_hour(8'h03, 8'h01, 8'h03);
        $display("test hour formats done");
        final_report();
    end
endmodule
